// ===== rtl/flash_host_pkg.sv
// Purpose: Shared constants for the byte-wide flash command host.
// Assumes: 10 MHz clock, byte addressing where bit 0 is the A-1 line.
// Notes: Command and address figures are hexadecimal bus values.
package flash_host_pkg;
  localparam int CLK_NS = 100;
  localparam int T_WP_NS = 35;
  localparam int T_ACC_NS = 70;
  localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_CYC = 2;
  localparam int RD_LOW_CYC = ACC_CYC + SYNC_CYC;

  localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [7:0] CMD_QUERY_EXIT_ALT = 8'hFF;
  localparam logic [7:0] CMD_SECURE_ENTRY = 8'h88;
  localparam logic [7:0] CMD_EXIT_PREFIX = 8'h90;
  localparam logic [7:0] CMD_EXIT_TAIL = 8'h00;
  localparam logic [7:0] CMD_AUTOSELECT = 8'h90;
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] CMD_BUF_LOAD = 8'h25;
  localparam logic [7:0] CMD_BUF_CONFIRM = 8'h29;
  localparam logic [7:0] CMD_QUERY = 8'h98;
  localparam logic [7:0] CMD_ECC_ENTRY = 8'h75;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_RESUME = 8'h30;

  localparam logic [11:0] ADDR_AAA = 12'hAAA;
  localparam logic [11:0] ADDR_555 = 12'h555;
  localparam logic [11:0] ADDR_QUERY = 12'h0AA;
  localparam logic [7:0] AS_PROT = 8'h04;
  localparam logic [7:0] AS_DEV1 = 8'h02;
  localparam logic [7:0] AS_DEV2 = 8'h1C;
  localparam logic [7:0] AS_DEV3 = 8'h1E;

  localparam int UNLOCK_BITS = 12;
  localparam int PAGE_BITS = 8;
  localparam int BUF_FIXED = 4;
  localparam int MAX_SEQ_CYCLES = 261;
  localparam int TIMEOUT_BIT = 5;
  localparam int PROT_BIT = 0;

  typedef enum logic [3:0] {
    OP_READ, OP_RESET, OP_SECURE_ENTRY, OP_SECURE_EXIT, OP_WORD_PROG,
    OP_BUF_PROG, OP_ABORT_RESET, OP_QUERY, OP_QUERY_EXIT_ALT,
    OP_ECC_ENTRY, OP_STATUS_READ, OP_AUTOSEL_READ, OP_DEVICE_ID,
    OP_SECTOR_ERASE, OP_SUSPEND, OP_RESUME
  } op_e;

  typedef enum logic [2:0] {
    MODE_ARRAY, MODE_AUTOSEL, MODE_SECURE, MODE_CFI, MODE_ECC,
    MODE_ERASING, MODE_SUSPENDED
  } mode_e;
endpackage : flash_host_pkg

// ===== rtl/flash_bus_cycle.sv
// Purpose: One write or read cycle on the flash pins.
// Assumes: Chip select held low for the whole cycle.
// Notes: Read data passes two flip-flops before capture.
`timescale 1ns/1ns
module flash_bus_cycle import flash_host_pkg::*; #(
  parameter int AW = 23
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic start_i,
  input wire logic read_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [7:0] data_i,
  output logic done_o,
  output logic [7:0] rdata_o,
  output logic [AW-1:0] addr_o,
  output logic [7:0] dq_o,
  output logic dq_oe_b_o,
  input wire logic [7:0] dq_i,
  output logic ce_b_o,
  output logic we_b_o,
  output logic oe_b_o
);
  typedef enum logic [1:0] {CY_IDLE, CY_SETUP, CY_STROBE, CY_HOLD} cy_e;
  cy_e cy, next_cy;
  logic rd, next_rd;
  logic [3:0] cnt, next_cnt;
  logic [7:0] dq_meta, dq_sync;
  logic [7:0] next_rdata, next_dq;
  logic [AW-1:0] next_addr;
  logic next_done, next_oe_dq_b, next_ce_b, next_we_b, next_oe_b;

  always_comb begin
    next_cy = cy;
    next_rd = rd;
    next_cnt = cnt;
    next_rdata = rdata_o;
    next_addr = addr_o;
    next_dq = dq_o;
    next_done = 1'b0;
    next_oe_dq_b = dq_oe_b_o;
    next_ce_b = ce_b_o;
    next_we_b = 1'b1;
    next_oe_b = 1'b1;
    case (cy)
      CY_IDLE: if (start_i) begin
        next_cy = CY_SETUP;
        next_rd = read_i;
        next_addr = addr_i;
        next_dq = data_i;
        next_ce_b = 1'b0;
        next_oe_dq_b = read_i;
      end
      CY_SETUP: begin
        // Address settles before the strobe falls
        next_cy = CY_STROBE;
        next_cnt = 4'(rd ? RD_LOW_CYC : WP_CYC);
        next_we_b = rd;
        next_oe_b = !rd;
      end
      CY_STROBE: begin
        next_cnt = cnt - 4'h1;
        next_we_b = rd;
        next_oe_b = !rd;
        if (cnt == 4'h1) begin
          next_cy = CY_HOLD;
          next_we_b = 1'b1;
          next_oe_b = 1'b1;
          if (rd) next_rdata = dq_sync;
        end
      end
      CY_HOLD: begin
        // Data stays driven across the rising strobe
        next_cy = CY_IDLE;
        next_ce_b = 1'b1;
        next_oe_dq_b = 1'b1;
        next_done = 1'b1;
      end
      default: next_cy = CY_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    dq_meta <= dq_i;
    dq_sync <= dq_meta;
    if (!rst_b_i) begin
      cy <= CY_IDLE;
      rd <= 1'b0;
      cnt <= 4'h0;
      rdata_o <= 8'h00;
      addr_o <= '0;
      dq_o <= 8'h00;
      done_o <= 1'b0;
      dq_oe_b_o <= 1'b1;
      ce_b_o <= 1'b1;
      we_b_o <= 1'b1;
      oe_b_o <= 1'b1;
    end else begin
      cy <= next_cy;
      rd <= next_rd;
      cnt <= next_cnt;
      rdata_o <= next_rdata;
      addr_o <= next_addr;
      dq_o <= next_dq;
      done_o <= next_done;
      dq_oe_b_o <= next_oe_dq_b;
      ce_b_o <= next_ce_b;
      we_b_o <= next_we_b;
      oe_b_o <= next_oe_b;
    end
  end

  sequence s_write_low;
    !we_b_o && !ce_b_o;
  endsequence

  AST_ADDR_HELD: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    s_write_low |=> $stable(addr_o) && !ce_b_o)
    else $error("address moved during write strobe");
  AST_DATA_AT_RISE: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    $rose(we_b_o) |-> !dq_oe_b_o && !ce_b_o && $stable(dq_o))
    else $error("data not held at write strobe rise");
endmodule : flash_bus_cycle

// ===== rtl/flash_seq_host.sv
// Purpose: Host sequencer issuing command sequences to a byte-wide flash.
// Assumes: One request at a time; bus cycles run by flash_bus_cycle.
// Notes: Tracks the device mode to refuse commands it would ignore.
`timescale 1ns/1ns
module flash_seq_host import flash_host_pkg::*; #(
  parameter int AW = 23,
  parameter int SECTOR_LSB = 16
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic start_i,
  input wire op_e op_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [7:0] data_i,
  input wire logic [7:0] count_i,
  input wire logic load_valid_i,
  input wire logic [AW-1:0] load_addr_i,
  input wire logic [7:0] load_data_i,
  output logic load_ready_o,
  output logic busy_o,
  output logic done_o,
  output logic refused_o,
  output logic [7:0] rdata_o,
  output logic [23:0] id_o,
  output logic protected_o,
  output logic timeout_o,
  output mode_e mode_o,
  output logic [AW-1:0] addr_o,
  output logic [7:0] dq_o,
  output logic dq_oe_b_o,
  input wire logic [7:0] dq_i,
  output logic ce_b_o,
  output logic we_b_o,
  output logic oe_b_o,
  input wire logic ready_i
);
  localparam int EW = AW + 11;
  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT} st_e;

  function automatic logic [EW-1:0] seq_entry(input op_e op,
      input logic [8:0] step, input logic [AW-1:0] a, input logic [7:0] d,
      input logic [7:0] cnt, input logic [AW-1:0] la, input logic [7:0] ld);
    logic last, rd, ldf;
    logic [AW-1:0] ad, sect;
    logic [7:0] dt;
    sect = a;
    sect[SECTOR_LSB-1:0] = '0;
    last = 1'b0;
    rd = 1'b0;
    ldf = 1'b0;
    dt = CMD_UNLOCK1;
    ad = AW'(ADDR_AAA);
    if (step == 9'd1) begin
      ad = AW'(ADDR_555);
      dt = CMD_UNLOCK2;
    end
    case (op)
      OP_READ: begin
        rd = 1'b1;
        last = 1'b1;
        ad = a;
      end
      OP_RESET: begin
        dt = CMD_RESET;
        last = 1'b1;
      end
      OP_QUERY_EXIT_ALT: begin
        dt = CMD_QUERY_EXIT_ALT;
        last = 1'b1;
      end
      OP_QUERY: begin
        ad = AW'(ADDR_QUERY);
        dt = CMD_QUERY;
        last = 1'b1;
      end
      OP_SUSPEND: begin
        dt = CMD_SUSPEND;
        last = 1'b1;
      end
      OP_RESUME: begin
        dt = CMD_RESUME;
        last = 1'b1;
      end
      OP_STATUS_READ: begin
        if (step == 9'd0) dt = CMD_STATUS;
        else begin
          rd = 1'b1;
          last = 1'b1;
          ad = AW'(a[0]);
        end
      end
      OP_SECURE_ENTRY: if (step == 9'd2) begin
        dt = CMD_SECURE_ENTRY;
        last = 1'b1;
      end
      OP_ECC_ENTRY: if (step == 9'd2) begin
        dt = CMD_ECC_ENTRY;
        last = 1'b1;
      end
      OP_ABORT_RESET: if (step == 9'd2) begin
        dt = CMD_RESET;
        last = 1'b1;
      end
      OP_SECURE_EXIT: begin
        if (step == 9'd2) dt = CMD_EXIT_PREFIX;
        if (step == 9'd3) begin
          dt = CMD_EXIT_TAIL;
          last = 1'b1;
        end
      end
      OP_WORD_PROG: begin
        if (step == 9'd2) dt = CMD_PROGRAM;
        if (step == 9'd3) begin
          ad = a;
          dt = d;
          last = 1'b1;
        end
      end
      OP_SECTOR_ERASE: begin
        if (step == 9'd2) dt = CMD_ERASE_SETUP;
        if (step == 9'd4) begin
          ad = AW'(ADDR_555);
          dt = CMD_UNLOCK2;
        end
        if (step == 9'd5) begin
          ad = sect;
          dt = CMD_SECTOR_ERASE;
          last = 1'b1;
        end
      end
      OP_AUTOSEL_READ: begin
        if (step == 9'd2) dt = CMD_AUTOSELECT;
        if (step == 9'd3) begin
          rd = 1'b1;
          last = 1'b1;
          ad = sect;
          ad[7:0] = a[7:0];
        end
      end
      OP_DEVICE_ID: begin
        if (step == 9'd2) dt = CMD_AUTOSELECT;
        if (step >= 9'd3) rd = 1'b1;
        if (step == 9'd3) ad = AW'(AS_DEV1);
        if (step == 9'd4) ad = AW'(AS_DEV2);
        if (step == 9'd5) begin
          ad = AW'(AS_DEV3);
          last = 1'b1;
        end
      end
      OP_BUF_PROG: begin
        if (step == 9'd2) begin
          ad = sect;
          dt = CMD_BUF_LOAD;
        end else if (step == 9'd3) begin
          ad = sect;
          dt = cnt;
        end else if (step >= 9'd4 && step <= {1'b0, cnt} + 9'd4) begin
          ldf = 1'b1;
          ad = {a[AW-1:PAGE_BITS], la[PAGE_BITS-1:0]};
          dt = ld;
        end else if (step > 9'd4) begin
          // Eight-bit count caps the sequence at 261 cycles
          ad = sect;
          dt = CMD_BUF_CONFIRM;
          last = 1'b1;
        end
      end
      default: last = 1'b1;
    endcase
    return {last, rd, ldf, ad, dt};
  endfunction : seq_entry

  st_e st, next_st;
  op_e req_op, next_op;
  mode_e next_mode;
  logic parked, next_parked;
  logic [8:0] step, next_step;
  logic [AW-1:0] req_addr, next_req_addr;
  logic [7:0] req_data, next_req_data, req_count, next_req_count;
  logic [7:0] next_rdata;
  logic [23:0] next_id;
  logic [8:0] loads, next_loads;
  logic next_done, next_refused, next_prot, next_timeout, ok;
  logic ready_meta, ready_sync, ready_prev;
  logic [EW-1:0] ent;
  logic ent_last, ent_rd, ent_ld, cyc_start, cyc_done;
  logic [AW-1:0] ent_addr;
  logic [7:0] ent_data, cyc_rdata;

  assign ent = seq_entry(req_op, step, req_addr, req_data, req_count,
                         load_addr_i, load_data_i);
  assign {ent_last, ent_rd, ent_ld, ent_addr, ent_data} = ent;
  assign busy_o = (st != ST_IDLE);
  assign load_ready_o = (st == ST_ISSUE) && ent_ld;
  assign cyc_start = (st == ST_ISSUE) && (!ent_ld || load_valid_i);

  always_comb begin
    ok = 1'b1;
    case (op_i)
      OP_QUERY: ok = (mode_o == MODE_ARRAY) || (mode_o == MODE_AUTOSEL);
      OP_SUSPEND: ok = (mode_o == MODE_ERASING);
      OP_RESUME: ok = (mode_o == MODE_SUSPENDED);
      OP_SECTOR_ERASE: ok = (mode_o != MODE_ERASING) && !parked;
      default: ok = 1'b1;
    endcase
  end

  always_comb begin
    next_st = st;
    next_op = req_op;
    next_mode = mode_o;
    next_parked = parked;
    next_step = step;
    next_req_addr = req_addr;
    next_req_data = req_data;
    next_req_count = req_count;
    next_rdata = rdata_o;
    next_id = id_o;
    next_loads = loads;
    next_done = 1'b0;
    next_refused = 1'b0;
    next_prot = protected_o;
    next_timeout = timeout_o;
    // Erase ends when the ready pin rises
    if (mode_o == MODE_ERASING && ready_sync && !ready_prev)
      next_mode = MODE_ARRAY;
    case (st)
      ST_IDLE: if (start_i) begin
        if (ok) begin
          next_st = ST_ISSUE;
          next_op = op_i;
          next_req_addr = addr_i;
          next_req_data = data_i;
          next_req_count = count_i;
          next_step = 9'd0;
          next_loads = 9'd0;
        end else begin
          next_refused = 1'b1;
        end
      end
      ST_ISSUE: if (cyc_start) begin
        next_st = ST_WAIT;
        if (ent_ld) next_loads = loads + 9'd1;
      end
      ST_WAIT: if (cyc_done) begin
        next_step = step + 9'd1;
        next_st = ST_ISSUE;
        if (ent_rd) begin
          next_rdata = cyc_rdata;
          if (req_op == OP_DEVICE_ID) next_id = {id_o[15:0], cyc_rdata};
          if (req_op == OP_AUTOSEL_READ && req_addr[7:0] == AS_PROT)
            next_prot = cyc_rdata[PROT_BIT];
          if (req_op == OP_STATUS_READ && cyc_rdata[TIMEOUT_BIT])
            next_timeout = 1'b1;
        end
        if (ent_last) begin
          next_st = ST_IDLE;
          next_done = 1'b1;
          case (req_op)
            OP_RESET, OP_ABORT_RESET, OP_SECURE_EXIT, OP_QUERY_EXIT_ALT: begin
              next_mode = parked ? MODE_SUSPENDED : MODE_ARRAY;
              if (req_op == OP_RESET) next_timeout = 1'b0;
            end
            OP_SECURE_ENTRY: next_mode = MODE_SECURE;
            OP_ECC_ENTRY: next_mode = MODE_ECC;
            OP_QUERY: next_mode = MODE_CFI;
            OP_AUTOSEL_READ, OP_DEVICE_ID: next_mode = MODE_AUTOSEL;
            OP_SECTOR_ERASE: next_mode = MODE_ERASING;
            OP_SUSPEND: begin
              next_mode = MODE_SUSPENDED;
              next_parked = 1'b1;
            end
            OP_RESUME: begin
              next_mode = MODE_ERASING;
              next_parked = 1'b0;
            end
            default: next_mode = next_mode;
          endcase
        end
      end
      default: next_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    ready_meta <= ready_i;
    ready_sync <= ready_meta;
    ready_prev <= ready_sync;
    if (!rst_b_i) begin
      st <= ST_IDLE;
      req_op <= OP_READ;
      mode_o <= MODE_ARRAY;
      parked <= 1'b0;
      step <= 9'd0;
      req_addr <= '0;
      req_data <= 8'h00;
      req_count <= 8'h00;
      rdata_o <= 8'h00;
      id_o <= 24'h000000;
      loads <= 9'd0;
      done_o <= 1'b0;
      refused_o <= 1'b0;
      protected_o <= 1'b0;
      timeout_o <= 1'b0;
    end else begin
      st <= next_st;
      req_op <= next_op;
      mode_o <= next_mode;
      parked <= next_parked;
      step <= next_step;
      req_addr <= next_req_addr;
      req_data <= next_req_data;
      req_count <= next_req_count;
      rdata_o <= next_rdata;
      id_o <= next_id;
      loads <= next_loads;
      done_o <= next_done;
      refused_o <= next_refused;
      protected_o <= next_prot;
      timeout_o <= next_timeout;
    end
  end

  flash_bus_cycle #(.AW(AW)) u_cycle (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .start_i(cyc_start),
    .read_i(ent_rd),
    .addr_i(ent_addr),
    .data_i(ent_data),
    .done_o(cyc_done),
    .rdata_o(cyc_rdata),
    .addr_o(addr_o),
    .dq_o(dq_o),
    .dq_oe_b_o(dq_oe_b_o),
    .dq_i(dq_i),
    .ce_b_o(ce_b_o),
    .we_b_o(we_b_o),
    .oe_b_o(oe_b_o)
  );

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  AST_UNLOCK_HIGH_ZERO: assert property (
    cyc_start && ent_data == CMD_UNLOCK2 && !ent_ld && step == 9'd1
    |-> ent_addr[AW-1:UNLOCK_BITS] == '0)
    else $error("unlock address carries high bits");
  AST_QUERY_REFUSED: assert property (
    st == ST_IDLE && start_i && op_i == OP_QUERY
    && mode_o != MODE_ARRAY && mode_o != MODE_AUTOSEL |=> refused_o && !busy_o)
    else $error("query issued outside read or autoselect");
  AST_RESUME_REFUSED: assert property (
    st == ST_IDLE && start_i && op_i == OP_RESUME
    && mode_o != MODE_SUSPENDED |=> refused_o)
    else $error("resume issued while not suspended");
  AST_CONFIRM: assert property (
    cyc_start && req_op == OP_BUF_PROG && ent_last
    |-> ent_data == CMD_BUF_CONFIRM && step == {1'b0, req_count} + 9'd5)
    else $error("buffer confirm misplaced");
  AST_LOAD_COUNT: assert property (
    done_o && req_op == OP_BUF_PROG |-> loads == {1'b0, req_count} + 9'd1)
    else $error("buffer load count differs from count plus one");
  AST_STATUS_BYTE: assert property (
    cyc_start && req_op == OP_STATUS_READ && step == 9'd1
    |-> ##2 addr_o[0] == req_addr[0])
    else $error("status byte select wrong");
  AST_RESET_MODE: assert property (
    done_o && req_op == OP_RESET
    |-> mode_o == (parked ? MODE_SUSPENDED : MODE_ARRAY) && !timeout_o)
    else $error("reset did not return to read mode");
  AST_CYCLE_DONE: assert property (
    cyc_start |-> ##[3:8] cyc_done)
    else $error("bus cycle did not finish");
endmodule : flash_seq_host

// ===== bench/flash_dev_model.sv
// Purpose: Behavioural byte-wide flash at the far side of the host.
// Assumes: Clockless device; mclk_i only paces the erase timer.
// Notes: Logs every write cycle as {address[11:0], data} for the bench.
`timescale 1ns/1ns
module flash_dev_model import flash_host_pkg::*; #(
  parameter int AW = 23,
  parameter logic [23:0] DEV_ID = 24'h3A5C71 // Arbitrary identifier
) (
  input wire logic mclk_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [7:0] dq_i,
  input wire logic ce_b_i,
  input wire logic we_b_i,
  input wire logic oe_b_i,
  input wire logic timeout_i,
  input wire logic prot_i,
  output logic [7:0] dq_o,
  output logic ready_o
);
  logic [19:0] wlog[$];
  logic [AW-1:0] la;
  logic [1:0] u = 2'd0;
  logic asel = 1'b0, stat = 1'b0, ers = 1'b0, susp = 1'b0;
  logic [7:0] rd = 8'h00;
  int etmr = 0;

  always @(negedge we_b_i) if (!ce_b_i) la = addr_i;
  always @(posedge we_b_i) if (!ce_b_i) begin
    wlog.push_back({la[11:0], dq_i});
    stat = (u == 0 && dq_i == 8'h70 && la[11:0] == 12'hAAA);
    if (dq_i == 8'hF0 || dq_i == 8'hFF) begin
      asel = 1'b0;
      u = 2'd0;
    end else if (u == 0 && dq_i == 8'hAA && la[11:0] == 12'hAAA) begin
      u = 2'd1;
    end else if (u == 1 && dq_i == 8'h55 && la[11:0] == 12'h555) begin
      u = 2'd2;
    end else begin
      if (u == 2 && dq_i == 8'h90) asel = 1'b1;
      if (u == 0 && dq_i == 8'h00) asel = 1'b0;
      if (u == 2 && dq_i == 8'h30) begin
        ers = 1'b1;
        etmr = 80;
      end
      if (u == 0 && dq_i == 8'hB0 && ers) begin
        ers = 1'b0;
        susp = 1'b1;
      end
      if (u == 0 && dq_i == 8'h30 && susp) begin
        susp = 1'b0;
        ers = 1'b1;
      end
      u = 2'd0;
    end
  end

  always @(posedge mclk_i) if (ers) begin
    if (etmr > 0) etmr--;
    else ers = 1'b0;
  end
  assign ready_o = !ers;

  always @(negedge oe_b_i) if (!ce_b_i) begin
    if (stat) rd = addr_i[0] ? 8'h3C : {2'b10, timeout_i, 5'h01};
    else if (asel) begin
      case (addr_i[7:0])
        8'h02: rd = DEV_ID[23:16];
        8'h1C: rd = DEV_ID[15:8];
        8'h1E: rd = DEV_ID[7:0];
        8'h04: rd = {7'h00, prot_i};
        default: rd = 8'h00;
      endcase
    end else rd = addr_i[7:0] ^ 8'h5A;
  end
  // Released bus shows the inverse so a stale sample cannot match
  assign dq_o = (!ce_b_i && !oe_b_i) ? rd : ~rd;
endmodule : flash_dev_model

// ===== bench/tb_top.sv
// Purpose: Self-checking bench for the flash command host.
// Assumes: Behavioural flash model on the pin side.
// Notes: Write cycles are compared through the model's write log.
`timescale 1ns/1ns
module tb_top import flash_host_pkg::*;;
  localparam logic [23:0] DEV_ID = 24'h3A5C71; // Arbitrary identifier
  logic mclk = 0, rst_b = 0, start = 0, lv = 0, tflag = 0, prot = 0;
  op_e op = OP_READ;
  logic [22:0] addr = '0, page_base = '0, fa;
  logic [7:0] data = '0, count = '0, li = '0, rdata, dq_h, dq_d;
  logic load_ready, busy, done, refused, prot_o, tout, dq_oe_b;
  logic ce_b, we_b, oe_b, ready, got_ref;
  logic [23:0] id;
  mode_e mode;
  logic [19:0] exp[$];
  int num_errors = 0, checks_done = 0, cyc = 0;
  wire logic [22:0] la = {page_base[22:8], page_base[7:0] + li};
  wire logic [7:0] ld = li ^ 8'h3C;

  always #50 mclk = ~mclk;
  always @(posedge mclk) if (lv && load_ready === 1'b1) begin
    li <= li + 8'h01;
    if (li == count) lv <= 1'b0;
  end
  always @(posedge we_b) if (!ce_b) cmp("dq_oe_b", dq_oe_b, 1'b0);

  flash_seq_host uut (.mclk_i(mclk), .rst_b_i(rst_b), .start_i(start),
    .op_i(op), .addr_i(addr), .data_i(data), .count_i(count),
    .load_valid_i(lv), .load_addr_i(la), .load_data_i(ld),
    .load_ready_o(load_ready), .busy_o(busy), .done_o(done),
    .refused_o(refused), .rdata_o(rdata), .id_o(id),
    .protected_o(prot_o), .timeout_o(tout), .mode_o(mode), .addr_o(fa),
    .dq_o(dq_h), .dq_oe_b_o(dq_oe_b), .dq_i(dq_d), .ce_b_o(ce_b),
    .we_b_o(we_b), .oe_b_o(oe_b), .ready_i(ready));
  flash_dev_model #(.DEV_ID(DEV_ID)) m (.mclk_i(mclk), .addr_i(fa),
    .dq_i(dq_h), .ce_b_i(ce_b), .we_b_i(we_b), .oe_b_i(oe_b),
    .timeout_i(tflag), .prot_i(prot), .dq_o(dq_d), .ready_o(ready));

  task automatic cmp(input string nm, input logic [31:0] s, w);
    checks_done++;
    if (s !== w) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, w, s);
    end
  endtask : cmp
  task automatic ex(input logic [11:0] a, input logic [7:0] d);
    exp.push_back({a, d});
  endtask : ex
  task automatic ul();
    ex(12'hAAA, 8'hAA);
    ex(12'h555, 8'h55);
  endtask : ul
  task automatic chk_log();
    cmp("log_len", m.wlog.size(), exp.size());
    for (int i = 0; i < exp.size() && i < m.wlog.size(); i++)
      cmp("log", m.wlog[i], exp[i]);
  endtask : chk_log
  // Waits for done or refused; r is whether a refusal is expected
  task automatic go(input op_e o, input logic [22:0] a,
    input logic [7:0] d, c, input logic r);
    int n;
    n = 0;
    @(posedge mclk);
    m.wlog.delete();
    exp.delete();
    start <= 1'b1;
    op <= o;
    addr <= a;
    page_base <= a;
    data <= d;
    count <= c;
    li <= 8'h00;
    lv <= (o == OP_BUF_PROG);
    @(posedge mclk);
    start <= 1'b0;
    got_ref = 1'b0;
    while (done !== 1'b1 && n < 3000) begin
      @(negedge mclk);
      n++;
      if (refused === 1'b1) begin
        got_ref = 1'b1;
        break;
      end
    end
    cmp("answer", n < 3000, 1);
    cmp("refused", got_ref, r);
    cmp("busy", busy, 1'b0);
  endtask : go
  task automatic end_of_test();
    $display("Errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      end_of_test();
    end
  end

  initial begin
    logic [22:0] a;
    logic [7:0] d;
    int cts[3];
    void'($urandom(7));
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (4) begin
      a = $urandom;
      go(OP_READ, a, 8'h00, 8'h00, 0);
      cmp("rdata", rdata, a[7:0] ^ 8'h5A);
      chk_log();
    end
    repeat (3) begin
      a = $urandom;
      d = $urandom;
      go(OP_WORD_PROG, a, d, 8'h00, 0);
      ul();
      ex(12'hAAA, 8'hA0);
      ex(a[11:0], d);
      chk_log();
    end
    cts = '{0, 255, $urandom_range(1, 8)};
    foreach (cts[k]) begin
      a = $urandom;
      go(OP_BUF_PROG, a, 8'h00, cts[k][7:0], 0);
      ul();
      ex(12'h000, 8'h25);
      ex(12'h000, cts[k][7:0]);
      for (int i = 0; i <= cts[k]; i++)
        ex({a[11:8], a[7:0] + i[7:0]}, i[7:0] ^ 8'h3C);
      ex(12'h000, 8'h29);
      chk_log();
    end
    go(OP_SECURE_ENTRY, 23'h0, 8'h00, 8'h00, 0);
    ul();
    ex(12'hAAA, 8'h88);
    chk_log();
    cmp("mode", mode, MODE_SECURE);
    go(OP_QUERY, 23'h0, 8'h00, 8'h00, 1);
    go(OP_SECURE_EXIT, 23'h0, 8'h00, 8'h00, 0);
    ul();
    ex(12'hAAA, 8'h90);
    ex(12'hAAA, 8'h00);
    chk_log();
    cmp("mode", mode, MODE_ARRAY);
    go(OP_ECC_ENTRY, 23'h0, 8'h00, 8'h00, 0);
    ul();
    ex(12'hAAA, 8'h75);
    chk_log();
    cmp("mode", mode, MODE_ECC);
    go(OP_RESET, 23'h0, 8'h00, 8'h00, 0);
    ex(12'hAAA, 8'hF0);
    chk_log();
    cmp("mode", mode, MODE_ARRAY);
    go(OP_QUERY, 23'h0, 8'h00, 8'h00, 0);
    ex(12'h0AA, 8'h98);
    chk_log();
    cmp("mode", mode, MODE_CFI);
    go(OP_QUERY_EXIT_ALT, 23'h0, 8'h00, 8'h00, 0);
    ex(12'hAAA, 8'hFF);
    chk_log();
    cmp("mode", mode, MODE_ARRAY);
    for (int p = 1; p >= 0; p--) begin
      prot <= p[0];
      go(OP_AUTOSEL_READ, 23'h4, 8'h00, 8'h00, 0);
      cmp("protected", prot_o, p[0]);
      go(OP_QUERY, 23'h0, 8'h00, 8'h00, 0);
      go(OP_RESET, 23'h0, 8'h00, 8'h00, 0);
      cmp("mode", mode, MODE_ARRAY);
    end
    go(OP_DEVICE_ID, 23'h0, 8'h00, 8'h00, 0);
    cmp("id", id, DEV_ID);
    go(OP_RESET, 23'h0, 8'h00, 8'h00, 0);
    tflag <= 1'b1;
    go(OP_STATUS_READ, 23'h0, 8'h00, 8'h00, 0);
    cmp("status_lo", rdata, 8'hA1);
    cmp("timeout", tout, 1);
    go(OP_STATUS_READ, 23'h1, 8'h00, 8'h00, 0);
    cmp("status_hi", rdata, 8'h3C);
    go(OP_RESET, 23'h0, 8'h00, 8'h00, 0);
    cmp("timeout", tout, 0);
    tflag <= 1'b0;
    go(OP_ABORT_RESET, 23'h0, 8'h00, 8'h00, 0);
    ul();
    ex(12'hAAA, 8'hF0);
    chk_log();
    go(OP_SUSPEND, 23'h0, 8'h00, 8'h00, 1);
    go(OP_RESUME, 23'h0, 8'h00, 8'h00, 1);
    a = $urandom;
    go(OP_SECTOR_ERASE, a, 8'h00, 8'h00, 0);
    ul();
    ex(12'hAAA, 8'h80);
    ul();
    ex(12'h000, 8'h30);
    chk_log();
    cmp("sector", fa, {a[22:16], 16'h0000});
    cmp("mode", mode, MODE_ERASING);
    go(OP_SECTOR_ERASE, a, 8'h00, 8'h00, 1);
    go(OP_SUSPEND, 23'h0, 8'h00, 8'h00, 0);
    cmp("mode", mode, MODE_SUSPENDED);
    a = $urandom;
    go(OP_READ, a, 8'h00, 8'h00, 0);
    cmp("rdata", rdata, a[7:0] ^ 8'h5A);
    go(OP_RESET, 23'h0, 8'h00, 8'h00, 0);
    cmp("mode", mode, MODE_SUSPENDED);
    go(OP_RESUME, 23'h0, 8'h00, 8'h00, 0);
    cmp("mode", mode, MODE_ERASING);
    for (int n = 0; n < 300 && mode !== MODE_ARRAY; n++) @(negedge mclk);
    cmp("mode", mode, MODE_ARRAY);
    end_of_test();
  end
endmodule : tb_top
